// ==== srsc_asserts.sv ====
// checker for the link between host and sensor ends
// assumes one clock; taps link wires and sensor resets
`timescale 1ns/100ps
`default_nettype none
module srsc_asserts #(
   parameter int SCL_CYCLES = srsc_pkg::SCL_CYCLES,
   parameter int PCLK_DIV = srsc_pkg::PCLK_DIV
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // link
   input wire logic rst_pin_b,
   input wire logic standby,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic fsync,
   input wire logic fsync_sensor_oe,
   input wire logic pclk_pin,
   input wire logic frame_sync,
   // sensor internals
   input wire logic async_rstb,
   input wire logic sync_rstb,
   input wire logic analog_en,
   input wire logic frame_start
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic run_r;
   logic soft_r;
   int pin_cnt_r;
   int low_cnt_r;
   int str_cnt_r;
   // previous cycle, since the write itself drops both resets
   wire logic soft_go = reg_wr && reg_addr == srsc_pkg::SOFT_RESET_ADDR && reg_wdata[0] && run_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_r <= 1'b0;
         soft_r <= 1'b0;
      end else begin
         run_r <= async_rstb && sync_rstb;
         soft_r <= soft_go || (soft_r && !sync_rstb);
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_cnt_r <= 0;
         low_cnt_r <= 0;
         str_cnt_r <= 0;
      end else begin
         pin_cnt_r <= rst_pin_b ? 0 : pin_cnt_r + 1;
         low_cnt_r <= async_rstb ? 0 : low_cnt_r + 1;
         str_cnt_r <= (async_rstb && !sync_rstb) ? str_cnt_r + 1 : 0;
      end
   end
   sequence s_pin_low;
      !rst_pin_b [*8];
   endsequence
   sequence s_standby;
      standby [*8];
   endsequence
   a_hard_pin: assert property ($rose(rst_pin_b) |-> pin_cnt_r >= srsc_pkg::HARD_RST_MASTER_CLKS)
      else $error("reset pin released early");
   a_hard_drop: assert property (s_pin_low |-> ##[0:6] !async_rstb)
      else $error("hard reset not taken");
   a_soft_drop: assert property (soft_go |-> !async_rstb && !sync_rstb)
      else $error("soft reset did not drop resets");
   a_soft_hold: assert property (soft_r && $rose(async_rstb) |-> low_cnt_r inside {[SCL_CYCLES:SCL_CYCLES + 2]})
      else $error("serial hold length wrong");
   a_sync_stretch: assert property ($rose(sync_rstb) |-> str_cnt_r inside {[15 * PCLK_DIV:16 * PCLK_DIV + 1]})
      else $error("sync stretch length wrong");
   a_reset_order: assert property (!async_rstb |-> !sync_rstb)
      else $error("sync reset free while async held");
   a_softbit_idle: assert property (reg_rd && reg_addr == srsc_pkg::SOFT_RESET_ADDR && run_r |=> !reg_rdata[0])
      else $error("soft reset bit stuck");
   a_standby_quiet: assert property (s_standby |-> !analog_en && $stable(pclk_pin))
      else $error("activity in standby");
   a_slave_follow: assert property ($rose(fsync) && !fsync_sensor_oe && sync_rstb && !standby |-> ##[1:16] frame_start)
      else $error("slave ignored frame sync");
   a_frame_mark: assert property (frame_start |-> ##[0:2] frame_sync)
      else $error("frame start without frame sync");
endmodule
`default_nettype wire

// ==== srsc_host_end.sv ====
// host end: drives reset pin, standby, sensor registers and frame-sync pin
// assumes the software port is a plain strobe bus on ref_clk
`timescale 1ns/100ps
`default_nettype none
module srsc_host_end #(
   parameter int SOFT_WAIT = srsc_pkg::SCL_CYCLES + srsc_pkg::SYNC_STRETCH_PCLKS * srsc_pkg::PCLK_DIV
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // link
   srsc_link_if.host link,
   // software port
   input wire logic [7:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [31:0] cmd_rdata
);
   logic [3:0] ctrl_r;
   logic [15:0] busy_r;
   logic [3:0] hard_r;
   logic [2:0] fs_cnt_r;
   logic [7:0] dev_rd_r;
   logic dev_rd_pend_r;
   logic [srsc_pkg::PIX_W-1:0] cap_r;
   logic pclk_d_r;
   logic busy;
   logic soft_write;
   assign busy = (busy_r != 16'h0000) || (hard_r != 4'h0);
   assign soft_write = cmd_wr && !busy && cmd_addr == srsc_pkg::HOST_DEVWR_ADDR
                       && cmd_wdata[15:8] == srsc_pkg::SOFT_RESET_ADDR
                       && cmd_wdata[srsc_pkg::SOFT_RESET_BIT];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= srsc_pkg::HOST_CTRL_RESET;
      end else if (cmd_wr && cmd_addr == srsc_pkg::HOST_CTRL_ADDR) begin
         ctrl_r <= {cmd_wdata[3:1], 1'b0};
      end
   end

   // [R01] reset pin low for 8 clocks, then [R06] settle wait
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hard_r <= 4'(srsc_pkg::HARD_RST_MASTER_CLKS);
         busy_r <= 16'h0000;
      end else if (cmd_wr && !busy && cmd_addr == srsc_pkg::HOST_CTRL_ADDR
                   && cmd_wdata[srsc_pkg::CTRL_HARD_RST_BIT]) begin
         hard_r <= 4'(srsc_pkg::HARD_RST_MASTER_CLKS);
      end else if (hard_r != 4'h0) begin
         hard_r <= hard_r - 4'h1;
         busy_r <= 16'(SOFT_WAIT + 3);
      end else if (soft_write) begin
         // [R06] serial period plus 16 pclks
         busy_r <= 16'(SOFT_WAIT);
      end else if (busy_r != 16'h0000) begin
         busy_r <= busy_r - 16'h0001;
      end
   end
   assign link.rst_pin_b = (hard_r == 4'h0);
   assign link.standby = ctrl_r[srsc_pkg::CTRL_STANDBY_BIT];

   // sensor register access, one cycle each
   logic wr_go;
   logic rd_go;
   assign wr_go = cmd_wr && !busy && cmd_addr == srsc_pkg::HOST_DEVWR_ADDR;
   assign rd_go = cmd_wr && !busy && cmd_addr == srsc_pkg::HOST_DEVRD_ADDR;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         link.reg_addr <= 8'h00;
         link.reg_wdata <= 8'h00;
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         dev_rd_pend_r <= 1'b0;
         dev_rd_r <= 8'h00;
      end else begin
         link.reg_wr <= wr_go;
         link.reg_rd <= rd_go;
         if (wr_go || rd_go) begin
            link.reg_addr <= cmd_wdata[15:8];
            link.reg_wdata <= cmd_wdata[7:0];
         end
         dev_rd_pend_r <= link.reg_rd;
         if (dev_rd_pend_r) begin
            dev_rd_r <= link.reg_rdata;
         end
      end
   end

   // external frame sync pulse when host is master
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fs_cnt_r <= 3'h0;
      end else if (cmd_wr && cmd_addr == srsc_pkg::HOST_FSYNC_ADDR) begin
         fs_cnt_r <= 3'(srsc_pkg::FSYNC_PULSE_CYCLES);
      end else if (fs_cnt_r != 3'h0) begin
         fs_cnt_r <= fs_cnt_r - 3'h1;
      end
   end
   // [R08] host drives pin only as master
   assign link.fsync_host_o = (fs_cnt_r != 3'h0);
   assign link.fsync_host_oe = ctrl_r[srsc_pkg::CTRL_FSYNC_MASTER_BIT];

   // [R12] capture on chosen pclk edge
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pclk_d_r <= 1'b0;
         cap_r <= '0;
      end else begin
         pclk_d_r <= link.pclk_pin;
         if (ctrl_r[srsc_pkg::CTRL_FALL_EDGE_BIT] ? (pclk_d_r && !link.pclk_pin)
                                                  : (!pclk_d_r && link.pclk_pin)) begin
            cap_r <= link.pix_data;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_rdata <= 32'h00000000;
      end else if (cmd_rd) begin
         unique case (cmd_addr)
            srsc_pkg::HOST_CTRL_ADDR: cmd_rdata <= {28'h0000000, ctrl_r};
            srsc_pkg::HOST_STAT_ADDR: cmd_rdata <= {4'h0, cap_r, dev_rd_r, 7'h00, busy};
            default: cmd_rdata <= 32'h00000000;
         endcase
      end else begin
         cmd_rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ==== srsc_link_if.sv ====
// pins between host controller and sensor: reset, standby, register access,
// frame-sync pin and parallel output; resolves the shared frame-sync wire
`timescale 1ns/100ps
`default_nettype none
interface srsc_link_if;
   logic rst_pin_b;
   logic standby;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic fsync_host_o;
   logic fsync_host_oe;
   logic fsync_sensor_o;
   logic fsync_sensor_oe;
   logic fsync;
   logic pclk_pin;
   logic line_sync;
   logic frame_sync;
   logic [srsc_pkg::PIX_W-1:0] pix_data;
   // pulldown when nobody drives
   assign fsync = fsync_sensor_oe ? fsync_sensor_o : (fsync_host_oe ? fsync_host_o : 1'b0);
   modport host (output rst_pin_b, standby, reg_addr, reg_wdata, reg_wr, reg_rd,
                 fsync_host_o, fsync_host_oe,
                 input reg_rdata, fsync, pclk_pin, line_sync, frame_sync, pix_data);
   modport sensor (input rst_pin_b, standby, reg_addr, reg_wdata, reg_wr, reg_rd, fsync,
                   output reg_rdata, fsync_sensor_o, fsync_sensor_oe,
                   pclk_pin, line_sync, frame_sync, pix_data);
endinterface
`default_nettype wire

// ==== srsc_pkg.sv ====
// constants shared by both ends of the sensor reset/standby/sync link
// assumes a single 100 MHz ref_clk shared by host and sensor ends
package srsc_pkg;
   // sensor register map (bank A)
   localparam logic [7:0] SOFT_RESET_ADDR = 8'h1B;
   localparam int SOFT_RESET_BIT = 0;
   localparam logic [7:0] SOFT_RESET_RESET = 8'h00;
   localparam logic [7:0] SENSOR_CFG_ADDR = 8'h1C;
   localparam logic [7:0] SENSOR_CFG_RESET = 8'h00;
   localparam logic [7:0] SENSOR_STAT_ADDR = 8'h1D;
   localparam int CFG_MASTER_BIT = 0;
   localparam int CFG_LS_POL_BIT = 1;
   localparam int CFG_LS_OUTSIDE_BIT = 2;
   localparam int CFG_MIPI_BIT = 3;
   // host command registers
   localparam logic [7:0] HOST_CTRL_ADDR = 8'h00;
   localparam logic [7:0] HOST_DEVWR_ADDR = 8'h04;
   localparam logic [7:0] HOST_DEVRD_ADDR = 8'h08;
   localparam logic [7:0] HOST_STAT_ADDR = 8'h0C;
   localparam logic [7:0] HOST_FSYNC_ADDR = 8'h10;
   localparam int CTRL_HARD_RST_BIT = 0;
   localparam int CTRL_STANDBY_BIT = 1;
   localparam int CTRL_FSYNC_MASTER_BIT = 2;
   localparam int CTRL_FALL_EDGE_BIT = 3;
   localparam logic [3:0] HOST_CTRL_RESET = 4'h0;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int SCL_CYCLES = (SCL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STRETCH_PCLKS = 16;
   localparam int HARD_RST_MASTER_CLKS = 8;
   localparam int PCLK_DIV = 4;
   localparam int FSYNC_PULSE_CYCLES = 4;
   localparam int PIX_W = 12;
endpackage

// ==== srsc_sensor_end.sv ====
// sensor end: hard/soft reset sequencing, standby, frame-sync pin, dvp syncs
// assumes pin inputs arrive unsynchronised; one ref_clk drives everything
//
// Behaviour
// [R01] host holds reset pin low 8 clocks
// [R02] registers return to defaults after reset
// [R03] soft reset drops both resets one serial period
// [R04] then async released, sync held 16 pclks
// [R05] soft reset bit 0 at 1B self-clears
// [R06] host waits serial period plus 16 pclks
// [R07] standby stops analog and all digital clocks
// [R08] master drives frame sync, slave follows it
// [R09] line sync in window, polarity, vertical option
// [R10] frame sync marks start of frame
// [R11] low six data pins double as mipi
// [R12] receiver captures on chosen pclk edge
// [R13] sync reset asserts at once, releases on pclk
`timescale 1ns/100ps
`default_nettype none
module srsc_sensor_end #(
   parameter int SCL_CYCLES = srsc_pkg::SCL_CYCLES,
   parameter int PCLK_DIV = srsc_pkg::PCLK_DIV,
   parameter int H_TOTAL = 16,
   parameter int H_ACTIVE = 10,
   parameter int V_TOTAL = 8,
   parameter int V_ACTIVE = 5
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // link
   srsc_link_if.sensor link,
   // internal resets and status
   output logic async_rstb,
   output logic sync_rstb,
   output logic analog_en,
   output logic frame_start
);
   typedef enum logic [2:0] {
      SRSC_RUN = 3'b001,
      SRSC_HOLD = 3'b010,
      SRSC_STRETCH = 3'b100
   } srsc_rst_state_type;

   // pin synchronisers: 0 reset pin, 1 standby, 2 frame sync
   logic [2:0] pin_in;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] pin_r;
   assign pin_in = {link.fsync, link.standby, link.rst_pin_b};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_r[gi] <= 1'b0;
               s2_r[gi] <= 1'b0;
               s3_r[gi] <= 1'b0;
               pin_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= pin_in[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi]) begin
                  pin_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate
   logic rst_pin_low;
   logic stby;
   logic fsync_in;
   assign rst_pin_low = !pin_r[0];
   assign stby = pin_r[1];
   assign fsync_in = pin_r[2];

   // pixel clock divider, frozen in standby
   logic [7:0] div_r;
   logic pclk_tick;
   assign pclk_tick = !stby && (div_r == 8'(PCLK_DIV - 1));
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 8'h00;
      end else if (pclk_tick) begin
         div_r <= 8'h00;
      end else if (!stby) begin
         div_r <= div_r + 8'h01;
      end
   end

   // reset sequencer
   srsc_rst_state_type state_r;
   logic [15:0] cnt_r;
   logic [3:0] hard_cnt_r;
   logic hard_armed;
   logic soft_trig;
   logic [7:0] soft_reg_r;
   logic [7:0] cfg_r;
   // [R01] pin low long enough
   assign hard_armed = (hard_cnt_r == 4'(srsc_pkg::HARD_RST_MASTER_CLKS));
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hard_cnt_r <= 4'h0;
      end else if (!rst_pin_low) begin
         hard_cnt_r <= 4'h0;
      end else if (!hard_armed) begin
         hard_cnt_r <= hard_cnt_r + 4'h1;
      end
   end
   assign soft_trig = link.reg_wr && (link.reg_addr == srsc_pkg::SOFT_RESET_ADDR)
                      && link.reg_wdata[srsc_pkg::SOFT_RESET_BIT] && (state_r == SRSC_RUN);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         // full hold, so async reset cannot leak high before the pin filter arms
         state_r <= SRSC_HOLD;
         cnt_r <= 16'(SCL_CYCLES - 1);
      end else if (hard_armed) begin
         state_r <= SRSC_HOLD;
         cnt_r <= 16'(SCL_CYCLES - 1);
      end else begin
         unique case (state_r)
            SRSC_RUN: begin
               // [R03] both resets low
               if (soft_trig) begin
                  state_r <= SRSC_HOLD;
                  cnt_r <= 16'(SCL_CYCLES - 1);
               end
            end
            SRSC_HOLD: begin
               // [R03] one serial period
               if (cnt_r == 16'h0000) begin
                  state_r <= SRSC_STRETCH;
                  cnt_r <= 16'(srsc_pkg::SYNC_STRETCH_PCLKS);
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            SRSC_STRETCH: begin
               // [R04] sixteen pclk ticks, [R13] leave on a tick
               if (pclk_tick) begin
                  if (cnt_r == 16'h0001) begin
                     state_r <= SRSC_RUN;
                  end
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end
   // [R13] sync reset drops in the write cycle itself
   assign async_rstb = (state_r != SRSC_HOLD) && !soft_trig && !hard_armed;
   assign sync_rstb = (state_r == SRSC_RUN) && !soft_trig && !hard_armed;

   // register file
   logic [7:0] rdata_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_reg_r <= srsc_pkg::SOFT_RESET_RESET;
         cfg_r <= srsc_pkg::SENSOR_CFG_RESET;
      end else if (state_r == SRSC_HOLD) begin
         // [R02] defaults restored
         cfg_r <= srsc_pkg::SENSOR_CFG_RESET;
      end else if (soft_trig) begin
         soft_reg_r <= 8'h01;
      end else if (state_r == SRSC_STRETCH && pclk_tick && cnt_r == 16'h0001) begin
         // [R05] bit clears once done
         soft_reg_r <= srsc_pkg::SOFT_RESET_RESET;
      end else if (sync_rstb && link.reg_wr && link.reg_addr == srsc_pkg::SENSOR_CFG_ADDR) begin
         cfg_r <= link.reg_wdata;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else if (link.reg_rd) begin
         unique case (link.reg_addr)
            srsc_pkg::SOFT_RESET_ADDR: rdata_r <= soft_reg_r;
            srsc_pkg::SENSOR_CFG_ADDR: rdata_r <= cfg_r;
            srsc_pkg::SENSOR_STAT_ADDR: rdata_r <= {5'h00, stby, sync_rstb, async_rstb};
            default: rdata_r <= 8'h00;
         endcase
      end
   end
   assign link.reg_rdata = rdata_r;

   // [R07] analog off in standby
   assign analog_en = !stby;

   // frame timing, advanced only on pclk ticks
   logic [7:0] h_r;
   logic [7:0] v_r;
   logic fsync_d_r;
   logic slave_restart;
   logic is_master;
   assign is_master = cfg_r[srsc_pkg::CFG_MASTER_BIT];
   // [R08] slave restarts frame on incoming sync
   assign slave_restart = !is_master && fsync_in && !fsync_d_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fsync_d_r <= 1'b0;
      end else begin
         fsync_d_r <= fsync_in;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         h_r <= 8'h00;
         v_r <= 8'h00;
      end else if (!sync_rstb || slave_restart) begin
         h_r <= 8'h00;
         v_r <= 8'h00;
      end else if (pclk_tick) begin
         if (h_r == 8'(H_TOTAL - 1)) begin
            h_r <= 8'h00;
            v_r <= (v_r == 8'(V_TOTAL - 1)) ? 8'h00 : v_r + 8'h01;
         end else begin
            h_r <= h_r + 8'h01;
         end
      end
   end
   assign frame_start = sync_rstb && pclk_tick && h_r == 8'h00 && v_r == 8'h00;

   // output pins, registered
   logic pclk_r;
   logic ls_r;
   logic fs_r;
   logic [srsc_pkg::PIX_W-1:0] pix_r;
   logic h_win;
   logic v_win;
   logic [srsc_pkg::PIX_W-1:0] pix_val;
   assign h_win = h_r < 8'(H_ACTIVE);
   assign v_win = v_r < 8'(V_ACTIVE);
   assign pix_val = (h_win && v_win) ? {v_r[5:0], h_r[5:0]} : '0;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pclk_r <= 1'b0;
         ls_r <= 1'b0;
         fs_r <= 1'b0;
         pix_r <= '0;
      end else begin
         // [R07] no clock beat in standby
         pclk_r <= !stby && sync_rstb && (div_r < 8'(PCLK_DIV / 2));
         // [R09] window, option and polarity
         ls_r <= (h_win && (v_win || cfg_r[srsc_pkg::CFG_LS_OUTSIDE_BIT]))
                 ^ cfg_r[srsc_pkg::CFG_LS_POL_BIT];
         // [R10] high through the first line
         fs_r <= sync_rstb && v_r == 8'h00;
         if (cfg_r[srsc_pkg::CFG_MIPI_BIT]) begin
            // [R11] clk_n, clk_p, lane1 n/p, lane0 n/p
            pix_r <= {pix_val[11:6], !pclk_r, pclk_r, !pix_val[1], pix_val[1], !pix_val[0], pix_val[0]};
         end else begin
            pix_r <= pix_val;
         end
      end
   end
   assign link.pclk_pin = pclk_r;
   assign link.line_sync = ls_r;
   assign link.frame_sync = fs_r;
   assign link.pix_data = pix_r;
   // [R08] master drives frame sync out
   assign link.fsync_sensor_o = fs_r;
   assign link.fsync_sensor_oe = is_master;
endmodule
`default_nettype wire

// ==== srsc_tb_top.sv ====
// self-checking bench: host end and sensor end joined by the link
// assumes 100 MHz ref_clk; serial period cut to SCL clocks
`timescale 1ns/100ps
`default_nettype none
module srsc_tb_top;
   localparam int SCL = 20;
   localparam int P = srsc_pkg::PCLK_DIV;
   localparam int H_T = 16;
   localparam int H_A = 10;
   localparam int V_T = 8;
   localparam int V_A = 5;
   localparam logic [7:0] CFG = srsc_pkg::SENSOR_CFG_ADDR;
   localparam logic [7:0] SRST = srsc_pkg::SOFT_RESET_ADDR;
   localparam logic [7:0] HCTRL = srsc_pkg::HOST_CTRL_ADDR;
   localparam logic [7:0] HSTAT = srsc_pkg::HOST_STAT_ADDR;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] cmd_addr = 8'h00;
   logic [31:0] cmd_wdata = 32'h0;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic [31:0] cmd_rdata;
   logic async_rstb;
   logic sync_rstb;
   logic analog_en;
   logic frame_start;
   int errors = 0;
   int num_checks = 0;
   srsc_link_if lnk();
   srsc_host_end #(.SOFT_WAIT(SCL + 16 * P + 8)) srsc_host_end_inst (.ref_clk(ref_clk), .rst_b(rst_b), .link(lnk),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
   srsc_sensor_end #(.SCL_CYCLES(SCL), .PCLK_DIV(P), .H_TOTAL(H_T), .H_ACTIVE(H_A), .V_TOTAL(V_T), .V_ACTIVE(V_A))
      srsc_sensor_end_inst (.ref_clk(ref_clk), .rst_b(rst_b), .link(lnk), .async_rstb(async_rstb),
      .sync_rstb(sync_rstb), .analog_en(analog_en), .frame_start(frame_start));
   srsc_asserts #(.SCL_CYCLES(SCL), .PCLK_DIV(P)) srsc_asserts_inst (.ref_clk(ref_clk), .rst_b(rst_b),
      .rst_pin_b(lnk.rst_pin_b), .standby(lnk.standby), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
      .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata), .fsync(lnk.fsync),
      .fsync_sensor_oe(lnk.fsync_sensor_oe), .pclk_pin(lnk.pclk_pin), .frame_sync(lnk.frame_sync),
      .async_rstb(async_rstb), .sync_rstb(sync_rstb), .analog_en(analog_en), .frame_start(frame_start));
   always #5 ref_clk = ~ref_clk;
   task automatic chk(input bit ok, input string msg);
      num_checks++;
      if (!ok) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // tasks return just after an edge so samples never race it
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
      step();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge ref_clk);
      cmd_rd <= 1'b0;
      #1 d = cmd_rdata;
      step();
   endtask
   task automatic swr(input logic [7:0] a, input logic [7:0] d);
      wr(srsc_pkg::HOST_DEVWR_ADDR, {16'h0000, a, d});
   endtask
   task automatic srd(input logic [7:0] a, output logic [7:0] d);
      logic [31:0] s;
      wr(srsc_pkg::HOST_DEVRD_ADDR, {16'h0000, a, 8'h00});
      repeat (3) step();
      rd(HSTAT, s);
      d = s[15:8];
   endtask
   task automatic idle();
      logic [31:0] s;
      int n;
      n = 0;
      s = 32'h1;
      while (s[0] !== 1'b0 && n < 400) begin
         rd(HSTAT, s);
         n++;
      end
      chk(n < 400, "host stays busy");
   endtask
   task automatic wait_fs(input int lim, output int n);
      n = 0;
      while (frame_start !== 1'b1 && n < lim) begin
         step();
         n++;
      end
   endtask
   task automatic t_soft();
      logic [7:0] v;
      int n;
      longint t0;
      swr(CFG, 8'h01);
      swr(SRST, 8'h01);
      chk(async_rstb === 1'b0 && sync_rstb === 1'b0, "resets not dropped"); // both low
      n = 0;
      while (async_rstb !== 1'b1 && n < 200) begin
         step();
         n++;
      end
      chk(n >= SCL - 2 && n <= SCL + 1, "serial hold length"); // hold span
      chk(sync_rstb === 1'b0, "sync released early"); // sync still low
      t0 = $time;
      // host refuses sensor reads while busy, so peek at the bit directly
      chk(srsc_sensor_end_inst.soft_reg_r[0] === 1'b1, "bit low mid sequence"); // reads set
      n = 0;
      while (sync_rstb !== 1'b1 && n < 400) begin
         step();
         n++;
      end
      chk(($time - t0) / 10 >= 15 * P && ($time - t0) / 10 <= 16 * P + 1, "stretch length"); // stretch
      idle();
      srd(SRST, v);
      chk(v === 8'h00, "bit not cleared"); // self clear
      srd(CFG, v);
      chk(v === srsc_pkg::SENSOR_CFG_RESET, "cfg kept after soft reset"); // defaults
      $display("test soft reset done");
   endtask
   task automatic t_hard();
      logic [7:0] v;
      logic [31:0] h;
      int n;
      swr(CFG, 8'h01);
      cmd_addr <= HCTRL;
      cmd_wdata <= 32'h1;
      cmd_wr <= 1'b1;
      step();
      cmd_wr <= 1'b0;
      n = 0;
      repeat (30) begin
         n += int'(lnk.rst_pin_b === 1'b0);
         step();
      end
      chk(n >= srsc_pkg::HARD_RST_MASTER_CLKS, "pin low too short"); // pin width
      idle();
      srd(CFG, v);
      chk(v === srsc_pkg::SENSOR_CFG_RESET, "cfg kept after hard reset"); // defaults
      rd(HCTRL, h);
      chk(h[0] === 1'b0, "hard bit stuck");
      $display("test hard reset done");
   endtask
   task automatic t_standby();
      logic [7:0] v;
      logic p;
      int moved;
      wr(HCTRL, 32'h2);
      repeat (8) step();
      p = lnk.pclk_pin;
      moved = 0;
      repeat (20) begin
         step();
         moved += int'(lnk.pclk_pin !== p);
      end
      chk(analog_en === 1'b0 && moved == 0, "activity in standby"); // quiet
      srd(srsc_pkg::SENSOR_STAT_ADDR, v);
      chk(v[2] === 1'b1, "standby not seen");
      wr(HCTRL, 32'h0);
      repeat (8) step();
      chk(analog_en === 1'b1, "analog stays off"); // wakes
      $display("test standby done");
   endtask
   task automatic t_frame(input logic [7:0] c);
      int n;
      int act;
      int bad;
      swr(CFG, c);
      wait_fs(2000, n);
      step();
      chk(n < 2000 && lnk.frame_sync === 1'b1, "frame start unmarked"); // frame mark
      act = 0;
      bad = 0;
      repeat (H_T * V_T * P) begin
         step();
         act += int'(lnk.line_sync === ~c[1]);
         bad += int'(c[3] && ({lnk.pix_data[1], lnk.pix_data[3], lnk.pix_data[5]} !==
            ~{lnk.pix_data[0], lnk.pix_data[2], lnk.pix_data[4]}));
      end
      chk(act == (c[2] ? V_T : V_A) * H_A * P, "line sync count"); // window
      chk(bad == 0, "pins not paired"); // pairs
      $display("test frame done");
   endtask
   task automatic t_fsync();
      int n;
      int hi;
      swr(CFG, 8'h00);
      wr(HCTRL, 32'h4);
      // natural frames are far apart, so three quick hits prove the restart
      repeat (3) begin
         repeat (150) step();
         wr(srsc_pkg::HOST_FSYNC_ADDR, 32'h0);
         wait_fs(30, n);
         chk(n < 30 && lnk.fsync_sensor_oe === 1'b0, "slave missed sync"); // slave
      end
      wr(HCTRL, 32'h0);
      swr(CFG, 8'h01);
      hi = 0;
      repeat (H_T * V_T * P + 8) begin
         step();
         hi += int'(lnk.fsync === 1'b1);
      end
      chk(lnk.fsync_sensor_oe === 1'b1 && hi > 0, "master sync absent"); // master
      $display("test frame sync done");
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      logic [7:0] v;
      logic [31:0] h;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      step();
      idle();
      srd(CFG, v);
      chk(v === srsc_pkg::SENSOR_CFG_RESET, "cfg default"); // cfg
      srd(SRST, v);
      chk(v === srsc_pkg::SOFT_RESET_RESET, "soft bit default"); // reset value
      rd(8'h3C, h);
      chk(h === 32'h0, "unmapped read");
      t_soft();
      t_hard();
      t_standby();
      t_frame(8'h00);
      t_frame(8'h02); // polarity
      t_frame(8'h04); // outside window
      t_frame(8'h08); // mipi mode
      t_fsync();
      finish_test();
   end
   initial begin
      #1000000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule
`default_nettype wire
